// *** shared/rfppm_defines.vh ***
`ifndef RFPPM_DEFINES_VH
`define RFPPM_DEFINES_VH

// ==========================================================
// Clock and air timing
`define RFPPM_CLK_PERIOD_NS 25
`define RFPPM_SLOT_NS 18880
`define RFPPM_HALF_SLOT_NS 9440
`define RFPPM_HALF_CYC (`RFPPM_HALF_SLOT_NS / `RFPPM_CLK_PERIOD_NS)
`define RFPPM_HALF_MID (`RFPPM_HALF_CYC / 2)
`define RFPPM_BYTE256_NS 4833000
`define RFPPM_BYTE4_NS 302080
`define RFPPM_POWERUP_NS 100000
`define RFPPM_POWERUP_CYC ((`RFPPM_POWERUP_NS + `RFPPM_CLK_PERIOD_NS - 1) / `RFPPM_CLK_PERIOD_NS)
`define RFPPM_TURN_NS 311500
`define RFPPM_TURN_CYC ((`RFPPM_TURN_NS + `RFPPM_CLK_PERIOD_NS - 1) / `RFPPM_CLK_PERIOD_NS)
`define RFPPM_GUARD_W 14

// ==========================================================
// Frame shapes: SOF in half slots from the first pause, windows in half slots from their start, last symbol of a byte
`define RFPPM_SOF4_EDGE 10'h005
`define RFPPM_SOF256_EDGE 10'h006
`define RFPPM_SOF_LAST 10'h007
`define RFPPM_WIN4_LAST 10'h007
`define RFPPM_WIN256_LAST 10'h1FF
`define RFPPM_SYM4_LAST 2'h3

// ==========================================================
// Modes, states, error causes, stream word marks
`define RFPPM_MODE_256 1'b0
`define RFPPM_MODE_4 1'b1
`define RFPPM_ST_IDLE 2'h0
`define RFPPM_ST_SOF 2'h1
`define RFPPM_ST_DATA 2'h2
`define RFPPM_ERR_NONE 2'h0
`define RFPPM_ERR_POS 2'h1
`define RFPPM_ERR_MISS 2'h2
`define RFPPM_ERR_OVR 2'h3
`define RFPPM_TAG_BYTE 2'h0
`define RFPPM_TAG_LAST 2'h1
`define RFPPM_TAG_ABORT 2'h2

`endif

// *** hw/rfppm_decoder.v ***
// What this block does
// - Reader speaks first; response allowed only after a good command frame.
// - Pauses of either modulation index arrive as one digital pause level.
// - One-of-256: one pause in 256 slots of 18.88 us; index is byte.
// - One-of-256: first slot gives 00h, last slot gives FFh.
// - One-of-256 byte lasts 4.833 ms, carrier over 8192.
// - One-of-four: one pause in four 18.88 us slots gives two bits.
// - One-of-four: first symbol is bits 1:0, fourth is bits 7:6.
// - One-of-four byte lasts 302.08 us, carrier over 512.
// - Frames open with SOF and close with EOF, both code violations.
// - The SOF pattern fixes the coding mode for the whole frame.
// - Ready for a new command 311.5 us after a response ends.
// - Wait 0.1 ms after power-up before accepting any frame.
`timescale 1ns/1ps
`include "rfppm_defines.vh"

// ==========================================================
// Byte stream FIFO
module rfppm_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clock,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire full;
  wire empty;
  wire do_wr;
  wire do_rd;

  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign do_wr = in_valid && !full;
  assign do_rd = out_ready && !empty;
  assign out_data = mem_q[rd_q[AW-1:0]];

  always @(posedge clock) begin
    if (do_wr) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_rd) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // rfppm_fifo

// ==========================================================
// Downlink pulse position frame decoder
module rfppm_decoder #(
  parameter [31:0] TURN_CYC = `RFPPM_TURN_CYC,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  input wire clock,
  input wire rst_n,
  input wire pause_in,
  input wire resp_busy,
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_data,
  output wire out_last,
  output wire out_abort,
  output wire rx_ready,
  output wire frame_active,
  output wire coding_mode,
  output reg resp_allowed,
  output reg frame_ok,
  output reg frame_err,
  output reg [1:0] err_cause
);
  localparam [`RFPPM_GUARD_W-1:0] TURN_LD = TURN_CYC[`RFPPM_GUARD_W-1:0] - 1'b1;
  localparam [31:0] POWERUP_32 = `RFPPM_POWERUP_CYC - 1;
  localparam [`RFPPM_GUARD_W-1:0] POWERUP_LD = POWERUP_32[`RFPPM_GUARD_W-1:0];
  localparam [31:0] HALF_32 = `RFPPM_HALF_CYC - 1;
  localparam [8:0] HALF_LD = HALF_32[8:0];
  localparam [31:0] MID_32 = `RFPPM_HALF_MID;
  localparam [8:0] MID_LD = MID_32[8:0];

  // ==========================================================
  // Pause input synchroniser
  reg pause_s1_q;
  reg pause_s2_q;
  reg pause_s3_q;
  wire pause_start;

  always @(posedge clock) begin
    if (!rst_n) begin
      pause_s1_q <= 1'b0;
      pause_s2_q <= 1'b0;
      pause_s3_q <= 1'b0;
    end else begin
      pause_s1_q <= pause_in;
      pause_s2_q <= pause_s1_q;
      pause_s3_q <= pause_s2_q;
    end
  end

  // Only the leading edge counts, so pause width (10% vs 100%) is irrelevant
  assign pause_start = pause_s2_q && !pause_s3_q;

  // ==========================================================
  // Power-up and turnaround guard
  reg [`RFPPM_GUARD_W-1:0] guard_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      guard_q <= POWERUP_LD;
    end else if (resp_busy) begin
      guard_q <= TURN_LD;
    end else if (guard_q != {`RFPPM_GUARD_W{1'b0}}) begin
      guard_q <= guard_q - 1'b1;
    end
  end

  assign rx_ready = (guard_q == {`RFPPM_GUARD_W{1'b0}});

  // ==========================================================
  // Frame state
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [9:0] h_q;
  reg [9:0] h_d;
  reg [8:0] div_q;
  reg [8:0] div_d;
  reg mode_q;
  reg mode_d;
  reg seen_q;
  reg seen_d;
  reg [7:0] sym_q;
  reg [7:0] sym_d;
  reg [5:0] shift_q;
  reg [5:0] shift_d;
  reg [1:0] nsym_q;
  reg [1:0] nsym_d;
  reg abort_q;
  reg abort_d;
  reg resp_d;
  reg ok_d;
  reg err_d;
  reg [1:0] cause_d;
  reg push_c;
  reg [9:0] push_w;
  reg [9:0] win_last;
  wire tick;
  wire fifo_in_ready;
  wire [9:0] fifo_out;

  // Tick sits mid half-slot so nominal pause edges never straddle it
  assign tick = (div_q == 9'h000);

  always @* begin
    state_d = state_q;
    h_d = h_q;
    div_d = tick ? HALF_LD : div_q - 1'b1;
    mode_d = mode_q;
    seen_d = seen_q;
    sym_d = sym_q;
    shift_d = shift_q;
    nsym_d = nsym_q;
    abort_d = abort_q;
    resp_d = resp_allowed;
    ok_d = 1'b0;
    err_d = 1'b0;
    cause_d = err_cause;
    push_c = 1'b0;
    push_w = 10'h000;
    win_last = (mode_q == `RFPPM_MODE_4) ? `RFPPM_WIN4_LAST : `RFPPM_WIN256_LAST;
    if (resp_busy) begin
      resp_d = 1'b0;
    end
    case (state_q)
      `RFPPM_ST_IDLE: begin
        div_d = MID_LD;
        if (abort_q) begin
          // Marker tells the consumer to drop the partial frame
          push_c = 1'b1;
          push_w = {`RFPPM_TAG_ABORT, 8'h00};
          if (fifo_in_ready) begin
            abort_d = 1'b0;
          end
        end else if (pause_start && rx_ready && !resp_busy) begin
          state_d = `RFPPM_ST_SOF;
          h_d = 10'h000;
          seen_d = 1'b0;
          resp_d = 1'b0;
        end
      end
      `RFPPM_ST_SOF: begin
        if (pause_start) begin
          if (!seen_q && h_q == `RFPPM_SOF4_EDGE) begin
            seen_d = 1'b1;
            mode_d = `RFPPM_MODE_4;
          end else if (!seen_q && h_q == `RFPPM_SOF256_EDGE) begin
            seen_d = 1'b1;
            mode_d = `RFPPM_MODE_256;
          end else begin
            state_d = `RFPPM_ST_IDLE;
          end
        end else if (tick) begin
          if (h_q == `RFPPM_SOF_LAST) begin
            h_d = 10'h000;
            seen_d = 1'b0;
            nsym_d = 2'h0;
            state_d = seen_q ? `RFPPM_ST_DATA : `RFPPM_ST_IDLE;
          end else begin
            h_d = h_q + 1'b1;
          end
        end
      end
      `RFPPM_ST_DATA: begin
        if (pause_start) begin
          if (h_q == 10'h000 && !seen_q && nsym_q == 2'h0) begin
            // EOF: pause in a first half at a byte boundary
            push_c = 1'b1;
            push_w = {`RFPPM_TAG_LAST, 8'h00};
            state_d = `RFPPM_ST_IDLE;
            if (fifo_in_ready) begin
              ok_d = 1'b1;
              resp_d = 1'b1;
            end else begin
              abort_d = 1'b1;
              err_d = 1'b1;
              cause_d = `RFPPM_ERR_OVR;
            end
          end else if (h_q[0] && !seen_q) begin
            // Second half of slot (h-1)/2 carries the value
            seen_d = 1'b1;
            sym_d = h_q[8:1];
          end else begin
            state_d = `RFPPM_ST_IDLE;
            abort_d = 1'b1;
            err_d = 1'b1;
            cause_d = `RFPPM_ERR_POS;
          end
        end else if (tick) begin
          if (h_q == win_last) begin
            h_d = 10'h000;
            seen_d = 1'b0;
            if (!seen_q) begin
              state_d = `RFPPM_ST_IDLE;
              abort_d = 1'b1;
              err_d = 1'b1;
              cause_d = `RFPPM_ERR_MISS;
            end else if (mode_q == `RFPPM_MODE_4) begin
              // Window of 8 halves per symbol, 4 symbols a byte
              shift_d = {sym_q[1:0], shift_q[5:2]};
              nsym_d = nsym_q + 1'b1;
              if (nsym_q == `RFPPM_SYM4_LAST) begin
                push_c = 1'b1;
                push_w = {`RFPPM_TAG_BYTE, sym_q[1:0], shift_q};
              end
            end else begin
              // Window of 512 halves is one byte
              push_c = 1'b1;
              push_w = {`RFPPM_TAG_BYTE, sym_q};
            end
            if (push_c && !fifo_in_ready) begin
              // Air cannot be stalled, so a full FIFO loses the frame
              state_d = `RFPPM_ST_IDLE;
              abort_d = 1'b1;
              err_d = 1'b1;
              cause_d = `RFPPM_ERR_OVR;
            end
          end else begin
            h_d = h_q + 1'b1;
          end
        end
      end
      default: begin
        state_d = `RFPPM_ST_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      state_q <= `RFPPM_ST_IDLE;
      h_q <= 10'h000;
      div_q <= 9'h000;
      mode_q <= `RFPPM_MODE_256;
      seen_q <= 1'b0;
      sym_q <= 8'h00;
      shift_q <= 6'h00;
      nsym_q <= 2'h0;
      abort_q <= 1'b0;
      resp_allowed <= 1'b0;
      frame_ok <= 1'b0;
      frame_err <= 1'b0;
      err_cause <= `RFPPM_ERR_NONE;
    end else begin
      state_q <= state_d;
      h_q <= h_d;
      div_q <= div_d;
      mode_q <= mode_d;
      seen_q <= seen_d;
      sym_q <= sym_d;
      shift_q <= shift_d;
      nsym_q <= nsym_d;
      abort_q <= abort_d;
      resp_allowed <= resp_d;
      frame_ok <= ok_d;
      frame_err <= err_d;
      err_cause <= cause_d;
    end
  end

  assign frame_active = (state_q != `RFPPM_ST_IDLE);
  assign coding_mode = mode_q;

  // ==========================================================
  // Output stream buffer
  rfppm_fifo #(
    .WIDTH(10),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(push_c),
    .in_ready(fifo_in_ready),
    .in_data(push_w),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );

  assign out_data = fifo_out[7:0];
  assign out_last = (fifo_out[9:8] == `RFPPM_TAG_LAST);
  assign out_abort = (fifo_out[9:8] == `RFPPM_TAG_ABORT);
endmodule // rfppm_decoder

// *** test/rfppm_chk_sva.sv ***
`timescale 1ns/1ps
// ==========
// Decoder port checks
module rfppm_chk #(
  parameter [31:0] TURN_CYC = 20
) (
  input wire clock,
  input wire rst_n,
  input wire resp_busy,
  input wire rx_ready,
  input wire frame_active,
  input wire resp_allowed,
  input wire frame_ok,
  input wire frame_err,
  input wire [1:0] err_cause,
  input wire out_valid,
  input wire out_last,
  input wire [7:0] out_data
);
  reg [15:0] cnt_q;
  reg seen_q;
  // Cycles since reset or since the last busy cycle
  always @(posedge clock) begin
    if (!rst_n || resp_busy) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q != 16'hFFFF) begin
      cnt_q <= cnt_q + 16'h0001;
    end
    seen_q <= rst_n && (seen_q || resp_busy);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_pwr; $rose(rx_ready) && !seen_q |-> cnt_q == 16'h0F9F; endproperty
  a_pwr: assert property (p_pwr) else $error("power-up guard length");
  property p_turn; $rose(rx_ready) && seen_q |-> cnt_q == TURN_CYC - 1; endproperty
  a_turn: assert property (p_turn) else $error("turnaround length");
  property p_busy; resp_busy |=> !rx_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_acc; $rose(frame_active) |-> $past(rx_ready) && !$past(resp_busy); endproperty
  a_acc: assert property (p_acc) else $error("frame taken while guarded");
  property p_ok; frame_ok |-> resp_allowed && !frame_active; endproperty
  a_ok: assert property (p_ok) else $error("good end without response grant");
  property p_clr; resp_busy [*2] ##0 !frame_ok |-> !resp_allowed; endproperty
  a_clr: assert property (p_clr) else $error("grant kept while busy");
  property p_pulse; frame_ok |=> !frame_ok; endproperty
  a_pulse: assert property (p_pulse) else $error("good end pulse too long");
  property p_err; frame_err |-> err_cause != 2'h0 && !frame_active && !frame_ok; endproperty
  a_err: assert property (p_err) else $error("abort without cause");
  property p_mark; out_valid && out_last |-> out_data == 8'h00; endproperty
  a_mark: assert property (p_mark) else $error("end marker carries data");
endmodule // rfppm_chk
bind rfppm_decoder rfppm_chk #(.TURN_CYC(TURN_CYC)) rfppm_chk_inst (
  .clock(clock), .rst_n(rst_n), .resp_busy(resp_busy), .rx_ready(rx_ready),
  .frame_active(frame_active), .resp_allowed(resp_allowed), .frame_ok(frame_ok),
  .frame_err(frame_err), .err_cause(err_cause), .out_valid(out_valid),
  .out_last(out_last), .out_data(out_data)
);

// *** test/rfppm_rdr.sv ***
`timescale 1ns/1ps
// ==========
// Reader pause generator
module rfppm_rdr #(
  parameter H = 377,
  parameter PW = 120
) (
  input wire clock,
  output reg pause_in
);
  integer now;
  integer base;
  initial begin
    pause_in = 1'b0;
    now = 0;
    base = 0;
  end
  always @(posedge clock) now <= now + 1;
  task automatic wait_hs(input integer hs);
    while (now - base < hs * H) @(posedge clock);
  endtask
  // Either modulation index ends up as one pause level
  task automatic pause_at(input integer hs);
    begin
      wait_hs(hs);
      #1 pause_in = 1'b1;
      repeat (PW) @(posedge clock);
      #1 pause_in = 1'b0;
      // Low across a few edges, else a following pause shows no rising edge
      repeat (3) @(posedge clock);
    end
  endtask
  task automatic sof(input bit four);
    begin
      base = now;
      pause_at(0);
      pause_at(four ? 5 : 6);
    end
  endtask
  // Odd half-slot of slot s; four windows of 8H make one byte
  task automatic byte4(input integer w, input [7:0] v);
    integer i;
    for (i = 0; i < 4; i = i + 1) pause_at(8 + 8 * (4 * w + i) + 2 * ((v >> 2 * i) & 3) + 1);
  endtask
endmodule // rfppm_rdr

// *** test/tb_top.sv ***
`timescale 1ns/1ps
// ==========
// Decoder bench
module tb_top;
  reg clock;
  reg rst_n;
  reg resp_busy;
  reg out_ready;
  reg hold;
  wire pause_in;
  wire out_valid;
  wire out_last;
  wire out_abort;
  wire rx_ready;
  wire frame_active;
  wire coding_mode;
  wire resp_allowed;
  wire frame_ok;
  wire frame_err;
  wire [7:0] out_data;
  wire [1:0] err_cause;
  reg [31:0] seed, r, rm;
  reg [9:0] expq [$];
  integer n_errors, samples_checked, i, k;
  rfppm_decoder #(.TURN_CYC(32'h00000014), .FIFO_DEPTH(4), .FIFO_AW(2)) rfppm_decoder_inst (
    .clock(clock), .rst_n(rst_n), .pause_in(pause_in), .resp_busy(resp_busy),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last),
    .out_abort(out_abort), .rx_ready(rx_ready), .frame_active(frame_active),
    .coding_mode(coding_mode), .resp_allowed(resp_allowed), .frame_ok(frame_ok),
    .frame_err(frame_err), .err_cause(err_cause));
  rfppm_rdr rfppm_rdr_inst (.clock(clock), .pause_in(pause_in));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task chk(input string what, input [9:0] exp, input [9:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task end_sim;
    begin
      $display("errors %0d comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  task wait_rdy;
    for (k = 0; k < 5000 && rx_ready !== 1'b1; k = k + 1) @(posedge clock);
  endtask
  task drain;
    for (k = 0; k < 3000 && expq.size() != 0; k = k + 1) @(posedge clock);
  endtask
  // Random consumer stalls exercise the buffer
  always @(posedge clock) begin
    if (rst_n && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (expq.size() == 0) begin
        chk("extra word", 10'h3FF, {out_abort, out_last, out_data});
      end else begin
        chk("word", expq.pop_front(), {out_abort, out_last, out_data});
      end
    end
    rm = $random(seed);
    #1 out_ready <= !hold && rm[0];
  end
  initial begin
    rst_n = 1'b0;
    resp_busy = 1'b0;
    out_ready = 1'b0;
    hold = 1'b0;
    seed = 32'h00000D42;
    n_errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge clock);
    #1 rst_n = 1'b1;
    rfppm_rdr_inst.sof(1'b1);
    chk("early frame", 10'h000, {9'h000, frame_active});
    wait_rdy;
    r = $random(seed);
    expq.push_back({2'b00, 8'hE4});
    expq.push_back({2'b00, r[7:0]});
    expq.push_back(10'h100);
    rfppm_rdr_inst.sof(1'b1);
    chk("mode four", 10'h001, {9'h000, coding_mode});
    rfppm_rdr_inst.byte4(0, 8'hE4);
    rfppm_rdr_inst.byte4(1, r[7:0]);
    rfppm_rdr_inst.pause_at(72);
    chk("grant", 10'h001, {9'h000, resp_allowed});
    resp_busy = 1'b1;
    repeat (10) @(posedge clock);
    #1 resp_busy = 1'b0;
    chk("grant cleared", 10'h000, {9'h000, resp_allowed});
    wait_rdy;
    drain;
    // Stalled consumer: the fifth empty frame overruns the buffer
    hold = 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      expq.push_back(i < 4 ? 10'h100 : 10'h200);
      rfppm_rdr_inst.sof(1'b0);
      chk("mode 256", 10'h000, {9'h000, coding_mode});
      rfppm_rdr_inst.pause_at(8);
    end
    chk("overrun", 10'h003, {8'h00, err_cause});
    hold = 1'b0;
    // Pending abort marker blocks new frames until the buffer frees a slot
    drain;
    for (i = 1; i < 3; i = i + 1) begin
      expq.push_back(10'h200);
      rfppm_rdr_inst.sof(1'b1);
      if (i == 1) begin
        rfppm_rdr_inst.pause_at(10);
      end
      rfppm_rdr_inst.wait_hs(18);
      chk("cause", {8'h00, i[1:0]}, {8'h00, err_cause});
    end
    drain;
    chk("pending", 10'h000, 10'(expq.size()));
    end_sim;
  end
  initial begin
    repeat (80000) @(posedge clock);
    n_errors = n_errors + 1;
    end_sim;
  end
endmodule // tb_top
